// ===== shared/dsti_pkg.sv
// Package: register map, field layouts and constants for drive supervision
package dsti_pkg;

	// Register byte offsets
	localparam logic [7:0] OFF_CTRL     = 8'h00;
	localparam logic [7:0] OFF_PEAK     = 8'h04;
	localparam logic [7:0] OFF_ESTOPCUR = 8'h08;
	localparam logic [7:0] OFF_JITTER   = 8'h0c;
	localparam logic [7:0] OFF_ACK      = 8'h10;
	localparam logic [7:0] OFF_STATUS   = 8'h14;
	localparam logic [7:0] OFF_IRQSTAT  = 8'h18;
	localparam logic [7:0] OFF_IRQMASK  = 8'h1c;
	localparam logic [7:0] OFF_CURRENT  = 8'h20;

	// Control register fields
	localparam int CTRL_RANGE3A  = 0;
	localparam int CTRL_EMODE_LO = 1;
	localparam int CTRL_PITCH_LO = 3;
	localparam int CTRL_DIRNEG   = 5;
	localparam int CTRL_EM_TYPE  = 8;
	localparam int CTRL_EM_PROF  = 9;
	localparam int CTRL_EM_SENS  = 10;
	localparam int CTRL_WM_SENS  = 11;

	// Current in milliamps
	localparam logic [15:0] CUR_CEIL_2A = 16'h07d0;
	localparam logic [15:0] CUR_CEIL_3A = 16'h0bb8;

	// Pole pitch in micrometres
	localparam logic [15:0] PITCH_1MM_UM = 16'h03e8;
	localparam logic [15:0] PITCH_2MM_UM = 16'h07d0;
	localparam logic [15:0] PITCH_5MM_UM = 16'h1388;

	// Reset values
	localparam logic [31:0] RST_CTRL     = 32'h0000_0000;
	localparam logic [15:0] RST_PEAK     = 16'h0bb8;
	localparam logic [15:0] RST_ESTOPCUR = 16'h0000;
	// Default intervals: 1 ms each at 25 MHz
	localparam int          CLK_HZ       = 25_000_000;
	localparam int          JITTER_US    = 1000;
	localparam logic [23:0] RST_JITTER   = 24'(longint'(JITTER_US) * CLK_HZ / 1_000_000);
	localparam int          ACK_US       = 1000;
	localparam logic [23:0] RST_ACK      = 24'(longint'(ACK_US) * CLK_HZ / 1_000_000);

	// Interrupt bit positions
	localparam int IRQ_STATE   = 0;
	localparam int IRQ_ERROR   = 1;
	localparam int IRQ_WARN    = 2;
	localparam int IRQ_INPOS   = 3;
	localparam int IRQ_W       = 4;

	typedef enum logic [1:0] {
		EMODE_OFF    = 2'h0,
		EMODE_FREEZE = 2'h1,
		EMODE_SET    = 2'h2
	} dsti_emode_t;

	typedef enum logic [1:0] {
		PITCH_1MM = 2'h0,
		PITCH_2MM = 2'h1,
		PITCH_5MM = 2'h2
	} dsti_pitch_t;

	// Wishbone classic request
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} dsti_wb_req_t;

	// Fault sensing from the motor side
	typedef struct packed {
		logic typeMismatch;
		logic profileMissing;
		logic sensorAbsent;
		logic sensorMisMount;
	} dsti_faults_t;

endpackage

// ===== rtl/dsti_supervisor.sv
// Drive supervision: current limits, fault masks, e-stop, encoder setup, state inputs, acknowledge
// How it works
// (RULE_01) Range bit picks 3 A else 2 A
// (RULE_02) Lower programmed peak limit further clamps current
// (RULE_03) Motor type fault errors only when masked in
// (RULE_04) Profile missing fault gated by error mask
// (RULE_05) Stop mode off drives zero current
// (RULE_06) Stop mode freeze latches present current
// (RULE_07) Stop mode set drives emergency current
// (RULE_08) Emergency current visible only in set mode
// (RULE_09) Pitch 1, 2 or 5 mm scales position
// (RULE_10) Direction setting picks sine or cosine lead
// (RULE_11) Sensor absent fault gated by error mask
// (RULE_12) Sensor mounting warning gated, never error
// (RULE_13) Controller presents four-bit state code
// (RULE_14) New code adopted only after stable interval
// (RULE_15) In-position low for acknowledge interval after command
// (RULE_16) In-position high after interval and target reached
// (RULE_17) Any input change restarts stability count
// (RULE_18) Intervals counted in programmed clock cycles
//
// Added by the designer: the register addresses and the Wishbone slave port.
module dsti_supervisor #(
	parameter int CNT_W = 24
) (
	input  wire logic                   ref_clk,
	input  wire logic                   rst_n,
	input  wire dsti_pkg::dsti_wb_req_t wbReq,
	output logic [31:0]                 wbDatO,
	output logic                        wbAck,
	output logic                        irq,
	input  wire logic [3:0]             stateSel,
	input  wire logic                   cmdDone,
	input  wire logic                   targetReached,
	input  wire logic                   estop,
	input  wire dsti_pkg::dsti_faults_t faults,
	input  wire logic [15:0]            currentReq,
	input  wire logic                   sinLead,
	output logic [15:0]                 currentOut,
	output logic [15:0]                 pitchUm,
	output logic                        dirOutward,
	output logic [3:0]                  stateCode,
	output logic                        inPosition,
	output logic                        errorState,
	output logic                        warnActive
);
	import dsti_pkg::*;

	logic [31:0]      ctrl_q;
	logic [15:0]      peak_q, estopCur_q, frozen_q, curOut_q;
	logic [CNT_W-1:0] jitter_q, ackTime_q, stabCnt_q, ackCnt_q;
	logic [3:0]       sel1_q, sel2_q, selPrev_q, state_q;
	logic [3:0]       flt1_q, flt2_q;
	logic             estop1_q, estop2_q, estopPrev_q;
	logic             done1_q, done2_q, tgt1_q, tgt2_q, sin1_q, sin2_q;
	logic             inPos_q, wbAck_q, ackRun_q;
	logic [31:0]      rdData_q;
	logic [IRQ_W-1:0] irqStat_q, irqMask_q;

	// Pin inputs except currentReq pass two flip-flops before use
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sel1_q   <= 4'h0;
			sel2_q   <= 4'h0;
			flt1_q   <= 4'h0;
			flt2_q   <= 4'h0;
			estop1_q <= 1'b0;
			estop2_q <= 1'b0;
			done1_q  <= 1'b0;
			done2_q  <= 1'b0;
			tgt1_q   <= 1'b0;
			tgt2_q   <= 1'b0;
			sin1_q   <= 1'b0;
			sin2_q   <= 1'b0;
		end else begin
			sel1_q   <= stateSel;
			sel2_q   <= sel1_q;
			flt1_q   <= faults;
			flt2_q   <= flt1_q;
			estop1_q <= estop;
			estop2_q <= estop1_q;
			done1_q  <= cmdDone;
			done2_q  <= done1_q;
			tgt1_q   <= targetReached;
			tgt2_q   <= tgt1_q;
			sin1_q   <= sinLead;
			sin2_q   <= sin1_q;
		end
	end

	// Bus decode
	wire         busReq   = wbReq.cyc & wbReq.stb & ~wbAck_q;
	wire         busWr    = busReq & wbReq.we;
	wire         wrCtrl   = busWr & (wbReq.adr == OFF_CTRL);
	wire         wrPeak   = busWr & (wbReq.adr == OFF_PEAK);
	wire         wrEstop  = busWr & (wbReq.adr == OFF_ESTOPCUR);
	wire         wrJitter = busWr & (wbReq.adr == OFF_JITTER);
	wire         wrAck    = busWr & (wbReq.adr == OFF_ACK);
	wire         wrIrqSt  = busWr & (wbReq.adr == OFF_IRQSTAT);
	wire         wrIrqMk  = busWr & (wbReq.adr == OFF_IRQMASK);
	wire [31:0]  byteMask = {{8{wbReq.sel[3]}}, {8{wbReq.sel[2]}}, {8{wbReq.sel[1]}}, {8{wbReq.sel[0]}}};
	wire [31:0]  wrMerge  = (ctrl_q & ~byteMask) | (wbReq.dat & byteMask);

	// Configuration decode
	wire          range3A   = ctrl_q[CTRL_RANGE3A];
	dsti_emode_t  emode;
	dsti_pitch_t  pitchSel;
	assign emode    = dsti_emode_t'(ctrl_q[CTRL_EMODE_LO +: 2]);
	assign pitchSel = dsti_pitch_t'(ctrl_q[CTRL_PITCH_LO +: 2]);

	// Current limiting
	wire [15:0] rangeCeil = range3A ? CUR_CEIL_3A : CUR_CEIL_2A; // RULE_01
	wire [15:0] limit     = (peak_q < rangeCeil) ? peak_q : rangeCeil; // RULE_02
	wire [15:0] clamped   = (currentReq > limit) ? currentReq - (currentReq - limit) : currentReq;
	wire        estopRise = estop2_q & ~estopPrev_q;

	// Fault masking; sensing arrives through the synchroniser
	wire typeF = flt2_q[3];
	wire profF = flt2_q[2];
	wire sensF = flt2_q[1];
	wire mntW  = flt2_q[0];
	wire errNow  = (typeF & ctrl_q[CTRL_EM_TYPE])       // RULE_03
		| (profF & ctrl_q[CTRL_EM_PROF])                  // RULE_04
		| (sensF & ctrl_q[CTRL_EM_SENS]);                 // RULE_11
	wire warnNow = mntW & ctrl_q[CTRL_WM_SENS];         // RULE_12

	// Emergency stop current selection
	logic [15:0] curNext;
	always_comb begin
		if (!estop2_q) begin
			curNext = clamped;
		end else begin
			case (emode)
				EMODE_OFF:    curNext = 16'h0000; // RULE_05
				EMODE_FREEZE: curNext = estopRise ? curOut_q : frozen_q; // RULE_06
				EMODE_SET:    curNext = estopCur_q; // RULE_07
				default:      curNext = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			curOut_q    <= 16'h0000;
			frozen_q    <= 16'h0000;
			estopPrev_q <= 1'b0;
		end else begin
			curOut_q    <= curNext;
			estopPrev_q <= estop2_q;
			if (estopRise) begin
				frozen_q <= curOut_q; // RULE_06
			end
		end
	end

	// Encoder setup
	always_comb begin
		case (pitchSel)
			PITCH_1MM: pitchUm = PITCH_1MM_UM; // RULE_09
			PITCH_2MM: pitchUm = PITCH_2MM_UM;
			PITCH_5MM: pitchUm = PITCH_5MM_UM;
			default:   pitchUm = PITCH_1MM_UM;
		endcase
	end
	// Outward stroke when sine leads for positive, cosine leads for negative
	assign dirOutward = sin2_q ^ ctrl_q[CTRL_DIRNEG]; // RULE_10

	// State-select debounce
	wire selChanged = (sel2_q != selPrev_q); // RULE_17
	wire stable     = (stabCnt_q >= jitter_q); // RULE_18
	wire adopt      = stable & ~selChanged & (sel2_q != state_q); // RULE_14

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			selPrev_q <= 4'h0;
			stabCnt_q <= '0;
			state_q   <= 4'h0;
		end else begin
			selPrev_q <= sel2_q;
			if (selChanged) begin
				stabCnt_q <= '0; // RULE_17
			end else if (!stable) begin
				stabCnt_q <= stabCnt_q + 1'b1;
			end
			if (adopt) begin
				state_q <= sel2_q; // RULE_14
			end
		end
	end

	// Acknowledge timer on in-position
	wire ackExpired = ackRun_q & (ackCnt_q >= ackTime_q); // RULE_18
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ackCnt_q <= '0;
			ackRun_q <= 1'b0;
			inPos_q  <= 1'b0;
		end else begin
			if (done2_q) begin
				ackCnt_q <= '0;
				ackRun_q <= 1'b1;
				inPos_q  <= 1'b0; // RULE_15
			end else begin
				if (ackRun_q && !ackExpired) begin
					ackCnt_q <= ackCnt_q + 1'b1;
				end
				inPos_q <= ackExpired & tgt2_q; // RULE_16
			end
		end
	end

	// Interrupt events: set wins over write-one-to-clear
	wire [IRQ_W-1:0] irqEv;
	assign irqEv[IRQ_STATE] = adopt;
	assign irqEv[IRQ_ERROR] = errNow & ~errorState;
	assign irqEv[IRQ_WARN]  = warnNow & ~warnActive;
	assign irqEv[IRQ_INPOS] = ackExpired & tgt2_q & ~inPos_q;
	wire [IRQ_W-1:0] irqClr = wrIrqSt ? wbReq.dat[IRQ_W-1:0] : '0;

	// Register file and read mux
	logic [31:0] rdMux;
	always_comb begin
		case (wbReq.adr)
			OFF_CTRL:     rdMux = ctrl_q;
			OFF_PEAK:     rdMux = {16'h0000, peak_q};
			// Hidden unless set-current mode is chosen
			OFF_ESTOPCUR: rdMux = (emode == EMODE_SET) ? {16'h0000, estopCur_q} : 32'h0000_0000; // RULE_08
			OFF_JITTER:   rdMux = 32'(jitter_q);
			OFF_ACK:      rdMux = 32'(ackTime_q);
			OFF_STATUS:   rdMux = {20'h00000, warnActive, errorState, inPos_q, estop2_q, state_q, flt2_q};
			OFF_IRQSTAT:  rdMux = 32'(irqStat_q);
			OFF_IRQMASK:  rdMux = 32'(irqMask_q);
			OFF_CURRENT:  rdMux = {16'h0000, curOut_q};
			default:      rdMux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q     <= RST_CTRL;
			peak_q     <= RST_PEAK;
			estopCur_q <= RST_ESTOPCUR;
			jitter_q   <= CNT_W'(RST_JITTER);
			ackTime_q  <= CNT_W'(RST_ACK);
			irqStat_q  <= '0;
			irqMask_q  <= '0;
			wbAck_q    <= 1'b0;
			rdData_q   <= 32'h0000_0000;
			errorState <= 1'b0;
			warnActive <= 1'b0;
		end else begin
			wbAck_q    <= busReq;
			rdData_q   <= busReq ? rdMux : 32'h0000_0000;
			errorState <= errNow;
			warnActive <= warnNow;
			irqStat_q  <= (irqStat_q & ~irqClr) | irqEv;
			if (wrCtrl) begin
				ctrl_q <= wrMerge;
			end
			if (wrPeak) begin
				peak_q <= wbReq.dat[15:0];
			end
			if (wrEstop && emode == EMODE_SET) begin
				estopCur_q <= wbReq.dat[15:0]; // RULE_08
			end
			if (wrJitter) begin
				jitter_q <= wbReq.dat[CNT_W-1:0];
			end
			if (wrAck) begin
				ackTime_q <= wbReq.dat[CNT_W-1:0];
			end
			if (wrIrqMk) begin
				irqMask_q <= wbReq.dat[IRQ_W-1:0];
			end
		end
	end

	assign wbAck      = wbAck_q;
	assign wbDatO     = rdData_q;
	assign irq        = |(irqStat_q & irqMask_q);
	assign currentOut = curOut_q;
	assign stateCode  = state_q;
	assign inPosition = inPos_q;

	// Checks
	a_range_ceiling: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_01
		!estop2_q |=> curOut_q <= (($past(range3A)) ? CUR_CEIL_3A : CUR_CEIL_2A))
		else $error("current above range ceiling");
	a_peak_limit: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_02
		!estop2_q |=> curOut_q <= $past(peak_q))
		else $error("current above peak limit");
	a_error_masked: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_03
		(typeF & ctrl_q[CTRL_EM_TYPE]) |=> errorState)
		else $error("type fault not raising error");
	a_error_gate: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_04
		errorState |-> $past((typeF && ctrl_q[CTRL_EM_TYPE]) || (profF && ctrl_q[CTRL_EM_PROF])
			|| (sensF && ctrl_q[CTRL_EM_SENS])))
		else $error("error without an enabled fault");
	a_prof_error: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_04
		(profF && ctrl_q[CTRL_EM_PROF]) |=> errorState)
		else $error("profile fault not raising error");
	a_sens_error: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_11
		(sensF && ctrl_q[CTRL_EM_SENS]) |=> errorState)
		else $error("sensor fault not raising error");
	a_warn_masked: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_12
		(mntW && ctrl_q[CTRL_WM_SENS]) |=> warnActive)
		else $error("mounting warning not raised");
	a_estop_off: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_05
		(estop2_q && emode == EMODE_OFF) |=> curOut_q == 16'h0000)
		else $error("current not removed on stop");
	sequence s_freeze_start;
		estopRise && emode == EMODE_FREEZE;
	endsequence
	a_estop_freeze: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_06
		s_freeze_start ##1 (estop2_q && emode == EMODE_FREEZE) |-> curOut_q == $past(curOut_q))
		else $error("frozen current changed");
	a_freeze_hold: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_06
		(estop2_q && !estopRise && emode == EMODE_FREEZE) |=> curOut_q == $past(frozen_q))
		else $error("frozen current not held");
	a_stop_hidden: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_08
		(wrEstop && emode != EMODE_SET) |=> estopCur_q == $past(estopCur_q))
		else $error("hidden stop current written");
	a_estop_set: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_07
		(estop2_q && emode == EMODE_SET) |=> curOut_q == $past(estopCur_q))
		else $error("stop current not driven");
	a_warn_noerr: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_12
		(warnNow && !typeF && !profF && !sensF) |=> !errorState)
		else $error("warning forced error");
	a_sel_stable: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_14
		(state_q != $past(state_q)) |-> $past(stable) && $past(sel2_q) == state_q)
		else $error("state adopted before stable");
	a_sel_restart: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_17
		selChanged |=> stabCnt_q == '0)
		else $error("stability count not restarted");
	sequence s_cmd_seen;
		done2_q;
	endsequence
	a_ack_low: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_16
		$rose(inPos_q) |-> $past(ackExpired) && $past(tgt2_q))
		else $error("in-position rose early");
	a_done_low: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_15
		s_cmd_seen |=> !inPos_q)
		else $error("in-position not dropped");
	a_ack_count: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_18
		(ackRun_q && !ackExpired && !done2_q) |=> ackCnt_q == $past(ackCnt_q) + 1'b1)
		else $error("acknowledge count stalled");

endmodule

// ===== tb/dsti_ctrl_model.sv
// Higher-level controller model: state-select pins, command pulse, target flag
module dsti_ctrl_model (
	input  wire logic  ref_clk,
	input  wire logic  inPosition,
	output logic [3:0] stateSel,
	output logic       cmdDone,
	output logic       targetReached
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		stateSel = 4'h0;
		cmdDone = 1'b0;
		targetReached = 1'b0;
	end
	// Skewed pins: bounce every 3 cycles before settling on the code
	task automatic present(input logic [3:0] code, input logic [3:0] alt, input int n);
		for (int i = 0; i < 2 * n; i++) begin
			@(posedge ref_clk);
			stateSel <= i[0] ? code : alt;
			repeat (2) @(posedge ref_clk);
		end
		@(posedge ref_clk);
		stateSel <= code;
	endtask
	task automatic command(input logic target);
		@(posedge ref_clk);
		cmdDone <= 1'b1;
		targetReached <= target;
		@(posedge ref_clk);
		cmdDone <= 1'b0;
	endtask
	task automatic setTarget(input logic v);
		@(posedge ref_clk);
		targetReached <= v;
	endtask
	// Waits for the fall, then counts low cycles
	task automatic lowTime(output int n);
		n = 0;
		repeat (10) if (inPosition === 1'b1) @(posedge ref_clk);
		while (inPosition !== 1'b1 && n < 200) begin
			n++;
			@(posedge ref_clk);
		end
	endtask
endmodule

// ===== tb/dsti_supervisor_tb_top.sv
// Self-checking bench for the drive supervision block
module dsti_supervisor_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import dsti_pkg::*;
	localparam int JIT  = 6;
	localparam int ACKT = 6;
	logic         ref_clk;
	logic         rst_n;
	dsti_wb_req_t wbReq;
	logic [31:0]  wbDatO;
	logic         wbAck;
	logic         irq;
	logic [3:0]   stateSel;
	logic         cmdDone;
	logic         targetReached;
	logic         estop;
	dsti_faults_t faults;
	logic [15:0]  currentReq;
	logic         sinLead;
	logic [15:0]  currentOut;
	logic [15:0]  pitchUm;
	logic         dirOutward;
	logic [3:0]   stateCode;
	logic         inPosition;
	logic         errorState;
	logic         warnActive;
	logic [31:0]  rnd;
	logic [31:0]  q;
	logic [3:0]   code;
	logic [3:0]   prev;
	int           fails;
	int           checksDone;
	int           n;

	dsti_supervisor #(.CNT_W(24)) i_dsti_supervisor (.ref_clk(ref_clk), .rst_n(rst_n), .wbReq(wbReq),
		.wbDatO(wbDatO), .wbAck(wbAck), .irq(irq), .stateSel(stateSel), .cmdDone(cmdDone),
		.targetReached(targetReached), .estop(estop), .faults(faults), .currentReq(currentReq),
		.sinLead(sinLead), .currentOut(currentOut), .pitchUm(pitchUm), .dirOutward(dirOutward),
		.stateCode(stateCode), .inPosition(inPosition), .errorState(errorState), .warnActive(warnActive));
	dsti_ctrl_model i_dsti_ctrl_model (.ref_clk(ref_clk), .inPosition(inPosition), .stateSel(stateSel),
		.cmdDone(cmdDone), .targetReached(targetReached));

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	function automatic logic [31:0] nextRnd(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [15:0] expCur(input logic [15:0] req, input logic [15:0] peak, input logic r3);
		logic [15:0] lim;
		lim = r3 ? CUR_CEIL_3A : CUR_CEIL_2A;
		if (peak < lim) lim = peak;
		return (req < lim) ? req : lim;
	endfunction
	function automatic logic [1:0] expFlt(input logic [31:0] c, input dsti_faults_t f);
		return {(f.typeMismatch & c[CTRL_EM_TYPE]) | (f.profileMissing & c[CTRL_EM_PROF])
			| (f.sensorAbsent & c[CTRL_EM_SENS]), f.sensorMisMount & c[CTRL_WM_SENS]};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checksDone++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	// Classic single cycle; answer awaited, never assumed
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		int k;
		k = 0;
		@(posedge ref_clk);
		wbReq <= '{1'b1, 1'b1, we, a, 4'hf, d};
		@(posedge ref_clk);
		while (wbAck !== 1'b1 && k < 50) begin
			k++;
			@(posedge ref_clk);
		end
		r = wbDatO;
		wbReq <= '0;
		if (k >= 50) chk(32'h0, 32'h1, "bus timeout");
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		wb(1'b1, a, d, r);
	endtask
	task automatic rdChk(input logic [7:0] a, input logic [31:0] e, input string msg);
		logic [31:0] r;
		wb(1'b0, a, 32'h0, r);
		chk(r, e, msg);
	endtask
	task automatic endOfTest;
		$display("checks %0d mismatches %0d", checksDone, fails);
		if (fails == 0 && checksDone > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		#(40 * 40000);
		fails++;
		$display("MISMATCH %0t watchdog expired", $time);
		endOfTest();
	end

	initial begin
		rst_n = 1'b0;
		wbReq = '0;
		estop = 1'b0;
		faults = '0;
		currentReq = 16'h0;
		sinLead = 1'b0;
		rnd = 32'h5d21e7e5;
		fails = 0;
		checksDone = 0;
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		rdChk(OFF_CTRL, RST_CTRL, "ctrl reset");
		rdChk(OFF_PEAK, 32'(RST_PEAK), "peak reset");
		rdChk(OFF_JITTER, 32'(RST_JITTER), "jitter reset");
		rdChk(OFF_ACK, 32'(RST_ACK), "ack reset");
		wr(8'h40, 32'hffff_ffff);
		rdChk(8'h40, 32'h0, "unmapped");
		wr(OFF_JITTER, 32'(JIT));
		wr(OFF_ACK, 32'(ACKT));
		$display("test registers done");
		for (int i = 0; i < 12; i++) begin
			rnd = nextRnd(rnd);
			currentReq <= (i == 0) ? 16'hffff : {4'h0, rnd[27:16]};
			wr(OFF_PEAK, {20'h0, rnd[15:4]});
			wr(OFF_CTRL, {31'h0, rnd[0]});
			repeat (3) @(posedge ref_clk);
			chk(32'(currentOut), 32'(expCur(currentReq, {4'h0, rnd[15:4]}, rnd[0])), "current");
		end
		$display("test current done");
		for (int i = 0; i < 10; i++) begin
			rnd = nextRnd(rnd);
			faults <= dsti_faults_t'(rnd[15:12]);
			wr(OFF_CTRL, {20'h0, rnd[11:8], 8'h0});
			repeat (5) @(posedge ref_clk);
			chk(32'({errorState, warnActive}), 32'(expFlt({20'h0, rnd[11:8], 8'h0}, rnd[15:12])), "masks");
		end
		faults <= '0;
		$display("test faults done");
		wr(OFF_PEAK, 32'(RST_PEAK));
		currentReq <= 16'd1234;
		wr(OFF_CTRL, 32'h0);
		wr(OFF_ESTOPCUR, 32'd555);
		wr(OFF_CTRL, 32'(EMODE_SET) << CTRL_EMODE_LO);
		rdChk(OFF_ESTOPCUR, 32'h0, "stop current write hidden");
		wr(OFF_ESTOPCUR, 32'd777);
		for (int m = 0; m < 3; m++) begin
			wr(OFF_CTRL, 32'(m) << CTRL_EMODE_LO);
			rdChk(OFF_ESTOPCUR, (m == 2) ? 32'd777 : 32'h0, "stop current view");
			estop <= 1'b1;
			repeat (5) @(posedge ref_clk);
			currentReq <= 16'd500;
			repeat (5) @(posedge ref_clk);
			chk(32'(currentOut), (m == 0) ? 32'h0 : (m == 1) ? 32'd1234 : 32'd777, "stop");
			estop <= 1'b0;
			currentReq <= 16'd1234;
			repeat (5) @(posedge ref_clk);
			chk(32'(currentOut), 32'd1234, "after stop");
			rdChk(OFF_CURRENT, 32'd1234, "current register");
		end
		$display("test stop done");
		for (int p = 0; p < 6; p++) begin
			rnd = nextRnd(rnd);
			sinLead <= rnd[0];
			wr(OFF_CTRL, (32'(p / 2) << CTRL_PITCH_LO) | (32'(p % 2) << CTRL_DIRNEG));
			repeat (3) @(posedge ref_clk);
			chk(32'(pitchUm), (p < 2) ? 32'(PITCH_1MM_UM) : (p < 4) ? 32'(PITCH_2MM_UM) : 32'(PITCH_5MM_UM), "pitch");
			chk(32'(dirOutward), 32'(sinLead ^ p[0]), "direction");
		end
		$display("test encoder done");
		wr(OFF_IRQMASK, 32'h1 << IRQ_STATE);
		wr(OFF_IRQSTAT, 32'hf);
		prev = stateCode;
		for (int i = 0; i < 5; i++) begin
			rnd = nextRnd(rnd);
			code = (rnd[3:0] == prev) ? ~prev : rnd[3:0];
			if (i == 4) wr(OFF_IRQMASK, 32'h0);
			i_dsti_ctrl_model.present(code, code ^ 4'h8, 4);
			chk(32'(stateCode), 32'(prev), "transient code");
			repeat (JIT + 8) @(posedge ref_clk);
			chk(32'(stateCode), 32'(code), "adopted code");
			wb(1'b0, OFF_STATUS, 32'h0, q);
			chk(32'(q[7:4]), 32'(code), "status state");
			chk(32'(irq), (i == 4) ? 32'h0 : 32'h1, "state irq");
			wb(1'b0, OFF_IRQSTAT, 32'h0, q);
			chk(32'(q[IRQ_STATE]), 32'h1, "state sticky");
			wr(OFF_IRQSTAT, 32'h1 << IRQ_STATE);
			@(posedge ref_clk);
			chk(32'(irq), 32'h0, "irq cleared");
			prev = code;
		end
		$display("test state done");
		i_dsti_ctrl_model.setTarget(1'b1);
		repeat (ACKT + 10) @(posedge ref_clk);
		i_dsti_ctrl_model.command(1'b1);
		i_dsti_ctrl_model.lowTime(n);
		chk(32'(n >= ACKT && n <= ACKT + 6), 32'h1, "ack low time");
		i_dsti_ctrl_model.command(1'b0);
		repeat (ACKT + 10) @(posedge ref_clk);
		chk(32'(inPosition), 32'h0, "not at target");
		i_dsti_ctrl_model.setTarget(1'b1);
		repeat (5) @(posedge ref_clk);
		chk(32'(inPosition), 32'h1, "target reached");
		i_dsti_ctrl_model.command(1'b1);
		i_dsti_ctrl_model.lowTime(n);
		chk(32'(n >= ACKT && n <= ACKT + 6), 32'h1, "ack low after high");
		wb(1'b0, OFF_IRQSTAT, 32'h0, q);
		chk(32'(q[IRQ_INPOS]), 32'h1, "in-position sticky");
		$display("test acknowledge done");
		endOfTest();
	end
endmodule
